/* rtl/field_rx_pkg.sv */
package field_rx_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_LEN_CFG = 8'h04;
  localparam logic [7:0] OFS_NUM_FLD = 8'h08;
  localparam logic [7:0] OFS_STATUS  = 8'h0C;
  localparam logic [7:0] OFS_FLEN1   = 8'h10;
  localparam logic [7:0] OFS_FLEN5   = 8'h20;
  // ctrl fields
  localparam int CTRL_EN_BIT    = 0;
  localparam int CTRL_ABORT_BIT = 1;
  // length configuration fields
  localparam int LCFG_LFLD_LSB = 0;
  localparam int LCFG_VFLD_LSB = 4;
  localparam int LCFG_TWO_BIT  = 8;
  localparam int LCFG_POS_LSB  = 16;
  // status fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_CERR_BIT = 1;
  localparam int STAT_CNT_LSB  = 8;
  localparam int STAT_LEN_LSB  = 16;
  // reset values
  localparam logic [2:0]  RST_LEN_FLD = 3'h1;
  localparam logic [2:0]  RST_VAR_FLD = 3'h2;
  localparam logic [2:0]  RST_NUM_FLD = 3'h2;
  localparam logic [15:0] RST_FLEN1   = 16'h0001;
  localparam logic [15:0] RST_FLEN    = 16'h0000;
  localparam int          NUM_FIELDS  = 5;
  // axi responses
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_RUN  = 1'b1
  } rx_state_type;
endpackage : field_rx_pkg

/* rtl/byte_fifo.sv */
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
    $error("byte_fifo needs a power-of-two depth of at least 2");
  end

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0]      wr_ptr_ff;
  logic [AW:0]      rd_ptr_ff;
  logic             push;
  logic             pop;

  // honest full and empty from the extra pointer bit
  assign in_ready  = (wr_ptr_ff - rd_ptr_ff) != (AW+1)'(DEPTH);
  assign out_valid = wr_ptr_ff != rd_ptr_ff;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_ff[rd_ptr_ff[AW-1:0]];

  // storage
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff[AW-1:0]] <= in_data;
    end
  end

  // pointers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      if (push) wr_ptr_ff <= wr_ptr_ff + 1'b1;
      if (pop)  rd_ptr_ff <= rd_ptr_ff + 1'b1;
    end
  end
endmodule : byte_fifo

/* rtl/field_rx_parser.sv */
`timescale 1ns/1ps
// What this block does
// - variable field takes its byte count from length bytes inside the packet
// - software sets which field and byte offset hold the length
// - length bytes come before the variable field; other order refused
// - length may sit in field one to four
// - field holding the length has a fixed configured length
// - fixed fields may lie between length field and variable field
// - variable field may be field two to five
module field_rx_parser
  import field_rx_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // byte stream after sync word
  input  wire logic        pkt_start,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_valid,
  output logic             rx_ready,
  // tagged bytes out
  output logic [7:0]       out_data,
  output logic [2:0]       out_field,
  output logic             out_last,
  output logic             out_valid,
  input  wire logic        out_ready,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  if (FIFO_DEPTH < 2) begin : g_bad
    $error("field_rx_parser needs a fifo depth of at least 2");
  end

  // configuration
  logic               en_ff;
  logic [2:0]         len_fld_ff;
  logic [2:0]         var_fld_ff;
  logic               two_ff;
  logic [7:0]         len_pos_ff;
  logic [2:0]         num_fld_ff;
  logic [15:0]        flen_ff [NUM_FIELDS];
  // parser state
  rx_state_type       state_ff;
  logic [2:0]         field_ff;
  logic [15:0]        remain_ff;
  logic [7:0]         pos_ff;
  logic [15:0]        cap_ff;
  logic               len_done_ff;
  logic               fld_start_ff;
  logic [7:0]         pkt_cnt_ff;
  // bus state
  logic               aw_got_ff;
  logic               w_got_ff;
  logic [7:0]         awaddr_ff;
  logic [31:0]        wdata_ff;
  logic [3:0]         wstrb_ff;
  logic               bvalid_ff;
  logic [1:0]         bresp_ff;
  logic               rvalid_ff;
  logic [31:0]        rdata_ff;
  logic [1:0]         rresp_ff;
  // combinational
  logic               cfg_ok;
  logic               take;
  logic               do_wr;
  logic               abort;
  logic [15:0]        nxt_cap;
  logic               nxt_len_done;
  logic [2:0]         nxt_fld;
  logic               fifo_in_ready;
  logic [11:0]        fifo_out;

  // merge byte lanes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) old[8*i +: 8] = nw[8*i +: 8];
    end
    return old;
  endfunction : merge

  // byte count of a field, variable field uses the captured length
  function automatic logic [15:0] len_of(input logic [2:0] f, input logic [15:0] cap);
    if (f == var_fld_ff) return cap;
    return flen_ff[f - 3'h1];
  endfunction : len_of

  // first enabled non-empty field after f, zero when none remain
  function automatic logic [2:0] next_fld(input logic [2:0] f, input logic [15:0] cap);
    logic [2:0] r;
    r = 3'h0;
    for (int j = NUM_FIELDS; j >= 1; j--) begin
      if (3'(j) > f && 3'(j) <= num_fld_ff && len_of(3'(j), cap) != 16'h0000) r = 3'(j);
    end
    return r;
  endfunction : next_fld

  // layout check refuses packets on a bad setup
  assign cfg_ok = len_fld_ff >= 3'h1 && len_fld_ff <= 3'h4
               && var_fld_ff >= 3'h2 && var_fld_ff <= 3'h5
               && len_fld_ff < var_fld_ff
               && var_fld_ff <= num_fld_ff && num_fld_ff <= 3'h5
               && flen_ff[len_fld_ff - 3'h1] > 16'(len_pos_ff) + 16'(two_ff);

  assign take     = state_ff == ST_RUN && rx_valid && fifo_in_ready;
  // stray bytes outside a packet are dropped
  assign rx_ready = (state_ff == ST_RUN) ? fifo_in_ready : 1'b1;
  assign do_wr    = aw_got_ff && w_got_ff && !bvalid_ff;
  assign abort    = do_wr && awaddr_ff == OFS_CTRL && wstrb_ff[0] && wdata_ff[CTRL_ABORT_BIT];

  // length bytes picked from configured offset, high byte first
  always_comb begin
    nxt_cap      = cap_ff;
    nxt_len_done = len_done_ff;
    if (take && field_ff == len_fld_ff) begin
      if (two_ff && pos_ff == len_pos_ff) begin
        nxt_cap[15:8] = rx_data;
      end else if (pos_ff == len_pos_ff + 8'(two_ff)) begin
        nxt_cap[7:0]  = rx_data;
        nxt_len_done  = 1'b1;
      end
    end
  end

  always_comb nxt_fld = next_fld(field_ff, nxt_cap);

  // packet walk through the fields
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff     <= ST_IDLE;
      field_ff     <= 3'h0;
      remain_ff    <= 16'h0000;
      pos_ff       <= 8'h00;
      cap_ff       <= 16'h0000;
      len_done_ff  <= 1'b0;
      fld_start_ff <= 1'b0;
      pkt_cnt_ff   <= 8'h00;
    end else begin
      fld_start_ff <= 1'b0;
      cap_ff       <= nxt_cap;
      len_done_ff  <= nxt_len_done;
      if (abort) begin
        state_ff <= ST_IDLE;
      end else if (state_ff == ST_IDLE) begin
        if (pkt_start && en_ff && cfg_ok && next_fld(3'h0, 16'h0000) != 3'h0) begin
          state_ff     <= ST_RUN;
          field_ff     <= next_fld(3'h0, 16'h0000);
          remain_ff    <= len_of(next_fld(3'h0, 16'h0000), 16'h0000);
          pos_ff       <= 8'h00;
          cap_ff       <= 16'h0000;
          len_done_ff  <= 1'b0;
          fld_start_ff <= 1'b1;
        end
      end else if (take) begin
        if (remain_ff == 16'h0001) begin
          if (nxt_fld == 3'h0) begin
            state_ff   <= ST_IDLE;
            pkt_cnt_ff <= pkt_cnt_ff + 8'h01;
          end else begin
            field_ff     <= nxt_fld;
            remain_ff    <= len_of(nxt_fld, nxt_cap);
            pos_ff       <= 8'h00;
            fld_start_ff <= 1'b1;
          end
        end else begin
          remain_ff <= remain_ff - 16'h0001;
          pos_ff    <= pos_ff + 8'h01;
        end
      end
    end
  end

  // tagged bytes wait in the fifo, full fifo stalls the stream
  byte_fifo #(
    .WIDTH (12),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .in_data   ({rx_data, field_ff, remain_ff == 16'h0001 && nxt_fld == 3'h0}),
    .in_valid  (state_ff == ST_RUN && rx_valid),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out),
    .out_valid (out_valid),
    .out_ready (out_ready)
  );
  assign out_data  = fifo_out[11:4];
  assign out_field = fifo_out[3:1];
  assign out_last  = fifo_out[0];

  // write address and data taken in either order
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_got_ff <= 1'b0;
      w_got_ff  <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff  <= 32'h0000_0000;
      wstrb_ff  <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_got_ff <= 1'b0;
        w_got_ff  <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff  <= (awaddr_ff[1:0] == 2'h0 && awaddr_ff <= OFS_FLEN5 &&
                      awaddr_ff != OFS_STATUS) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end
  assign s_axi_awready = !aw_got_ff && !bvalid_ff;
  assign s_axi_wready  = !w_got_ff && !bvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;

  // configuration registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      en_ff      <= 1'b0;
      len_fld_ff <= RST_LEN_FLD;
      var_fld_ff <= RST_VAR_FLD;
      two_ff     <= 1'b0;
      len_pos_ff <= 8'h00;
      num_fld_ff <= RST_NUM_FLD;
      flen_ff[0] <= RST_FLEN1;
      for (int i = 1; i < NUM_FIELDS; i++) flen_ff[i] <= RST_FLEN;
    end else if (do_wr) begin
      unique case (awaddr_ff)
        OFS_CTRL: begin
          if (wstrb_ff[0]) en_ff <= wdata_ff[CTRL_EN_BIT];
        end
        OFS_LEN_CFG: begin
          if (wstrb_ff[0]) len_fld_ff <= wdata_ff[LCFG_LFLD_LSB +: 3];
          if (wstrb_ff[0]) var_fld_ff <= wdata_ff[LCFG_VFLD_LSB +: 3];
          if (wstrb_ff[1]) two_ff     <= wdata_ff[LCFG_TWO_BIT];
          if (wstrb_ff[2]) len_pos_ff <= wdata_ff[LCFG_POS_LSB +: 8];
        end
        OFS_NUM_FLD: begin
          if (wstrb_ff[0]) num_fld_ff <= wdata_ff[2:0];
        end
        default: begin
          for (int i = 0; i < NUM_FIELDS; i++) begin
            if (awaddr_ff == OFS_FLEN1 + 8'(4 * i)) begin
              flen_ff[i] <= 16'(merge({16'h0000, flen_ff[i]}, wdata_ff, wstrb_ff));
            end
          end
        end
      endcase
    end
  end

  // read channel, one cycle to answer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rresp_ff  <= RESP_OKAY;
      rdata_ff  <= 32'h0000_0000;
      unique case (s_axi_araddr)
        OFS_CTRL:    rdata_ff <= {31'h0000_0000, en_ff};
        OFS_LEN_CFG: rdata_ff <= {8'h00, len_pos_ff, 7'h00, two_ff, 1'b0, var_fld_ff,
                                  1'b0, len_fld_ff};
        OFS_NUM_FLD: rdata_ff <= {29'h0000_0000, num_fld_ff};
        OFS_STATUS:  rdata_ff <= {cap_ff, pkt_cnt_ff, 6'h00, !cfg_ok, state_ff == ST_RUN};
        default: begin
          rresp_ff <= RESP_SLVERR;
          for (int i = 0; i < NUM_FIELDS; i++) begin
            if (s_axi_araddr == OFS_FLEN1 + 8'(4 * i)) begin
              rdata_ff <= {16'h0000, flen_ff[i]};
              rresp_ff <= RESP_OKAY;
            end
          end
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  chk_var_from_len: assert property (
    fld_start_ff && field_ff == var_fld_ff |-> remain_ff == cap_ff && cap_ff != 16'h0000)
    else $error("variable field count differs from captured length");
  chk_len_byte_pos: assert property (
    take && field_ff == len_fld_ff && pos_ff == len_pos_ff + 8'(two_ff)
    |=> cap_ff[7:0] == $past(rx_data) && len_done_ff)
    else $error("length byte not captured at its offset");
  chk_len_before_var: assert property (
    state_ff == ST_RUN && field_ff == var_fld_ff |-> len_done_ff)
    else $error("variable field entered before length known");
  chk_len_fld_range: assert property (
    $rose(state_ff == ST_RUN) |-> $past(len_fld_ff) inside {[3'h1:3'h4]})
    else $error("packet started with length field out of range");
  chk_len_fld_fixed: assert property (
    fld_start_ff && field_ff == len_fld_ff |-> remain_ff == flen_ff[len_fld_ff - 3'h1])
    else $error("length field count not the fixed setting");
  chk_gap_fixed: assert property (
    fld_start_ff && field_ff > len_fld_ff && field_ff < var_fld_ff
    |-> remain_ff == flen_ff[field_ff - 3'h1])
    else $error("field between length and variable not fixed");
  chk_var_fld_range: assert property (
    $rose(state_ff == ST_RUN) |-> $past(var_fld_ff) inside {[3'h2:3'h5]} &&
    $past(len_fld_ff) < $past(var_fld_ff))
    else $error("packet started with variable field out of range");
  chk_after_var: assert property (
    take && remain_ff == 16'h0001 && field_ff == var_fld_ff && nxt_fld != 3'h0 && !abort
    |=> field_ff > var_fld_ff && remain_ff == flen_ff[field_ff - 3'h1])
    else $error("field after variable field not fixed or not later");
  chk_pkt_end: assert property (
    take && remain_ff == 16'h0001 && nxt_fld == 3'h0 && !abort
    |=> state_ff == ST_IDLE && pkt_cnt_ff == $past(pkt_cnt_ff) + 8'h01)
    else $error("packet did not end after last field");
endmodule : field_rx_parser

/* verif/remote_tx.sv */
`timescale 1ns/1ps
module remote_tx (
  input  wire logic       ref_clk,
  output logic            pkt_start,
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  input  wire logic       rx_ready
);
  // quiet line at time zero
  initial begin
    pkt_start = 1'b0;
    rx_data   = 8'h00;
    rx_valid  = 1'b0;
  end

  // one packet: start strobe, then each byte held until taken
  // caller builds length bytes ahead of the variable field, inside a fixed field
  task send(input logic [7:0] q[$]);
    @(posedge ref_clk);
    pkt_start <= 1'b1;
    @(posedge ref_clk);
    pkt_start <= 1'b0;
    foreach (q[i]) begin
      rx_data  <= q[i];
      rx_valid <= 1'b1;
      do @(posedge ref_clk); while (rx_ready !== 1'b1);
    end
    // released data shows inverse of last byte
    rx_valid <= 1'b0;
    rx_data  <= ~q[q.size()-1];
  endtask : send
endmodule : remote_tx

/* verif/field_rx_parser_tb.sv */
`timescale 1ns/1ps
module field_rx_parser_tb;
  import field_rx_pkg::*;
  logic        ref_clk, rst_n, pkt_start, rx_valid, rx_ready;
  logic [7:0]  rx_data, out_data, s_axi_awaddr, s_axi_araddr;
  logic [2:0]  out_field;
  logic        out_last, out_valid, out_ready;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          miscompares, n_checks, cycles, n_pkts;
  logic [11:0] got[$];

  field_rx_parser #(.FIFO_DEPTH(8)) uut (.ref_clk(ref_clk), .rst_n(rst_n),
    .pkt_start(pkt_start), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .out_data(out_data), .out_field(out_field), .out_last(out_last),
    .out_valid(out_valid), .out_ready(out_ready),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  remote_tx tx (.ref_clk(ref_clk), .pkt_start(pkt_start), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready));

  task results;
    if (miscompares == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results

  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("Error at %0t ns: got %h expected %h", $time, g, e);
    end
  endtask : chk

  // axi write: address and data offered together, each released when taken
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge ref_clk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    forever begin
      @(posedge ref_clk);
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask : wr

  // axi read, masked data compare
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er,
          input logic [31:0] m);
    @(posedge ref_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    forever begin
      @(posedge ref_clk);
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata & m, e);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask : rd

  task cfg(input logic [2:0] lf, input logic [2:0] vf, input logic two,
           input logic [7:0] pos, input logic [2:0] last, input logic [15:0] fl [5]);
    wr(OFS_LEN_CFG, {8'h00, pos, 7'h00, two, 1'b0, vf, 1'b0, lf}, RESP_OKAY);
    wr(OFS_NUM_FLD, {29'h0, last}, RESP_OKAY);
    for (int i = 0; i < 5; i++) wr(OFS_FLEN1 + 8'(4 * i), {16'h0, fl[i]}, RESP_OKAY);
    wr(OFS_CTRL, 32'h0000_0001, RESP_OKAY);
  endtask : cfg

  // one packet through a layout; expected tags built field by field
  task automatic pkt(input logic [2:0] lf, input logic [2:0] vf, input logic two,
           input logic [7:0] pos, input logic [2:0] last, input logic [15:0] fl [5],
           input logic [15:0] len, input logic stall);
    logic [7:0]  q[$];
    logic [11:0] ex[$];
    logic [7:0]  b;
    int          n;
    cfg(lf, vf, two, pos, last, fl);
    got.delete();
    for (int f = 1; f <= int'(last); f++) begin
      n = (f == int'(vf)) ? int'(len) : int'(fl[f-1]);
      for (int k = 0; k < n; k++) begin
        b = 8'hA0 + 8'(q.size());
        if (f == int'(lf) && k == int'(pos)) b = two ? len[15:8] : len[7:0];
        if (f == int'(lf) && two && k == int'(pos) + 1) b = len[7:0];
        q.push_back(b);
        ex.push_back({1'b0, 3'(f), b});
      end
    end
    ex[ex.size()-1][11] = 1'b1;
    if (stall) begin
      out_ready <= 1'b0;
      fork
        tx.send(q);
        begin
          repeat (20) @(posedge ref_clk);
          chk({31'h0, rx_ready}, 32'h0);
          out_ready <= 1'b1;
        end
      join
    end else tx.send(q);
    for (int k = 0; k < 60 && got.size() < ex.size(); k++) @(posedge ref_clk);
    chk(got.size(), ex.size());
    if (got.size() == ex.size()) foreach (ex[i]) chk({20'h0, got[i]}, {20'h0, ex[i]});
    n_pkts++;
    rd(OFS_STATUS, {len, 8'(n_pkts), 8'h00}, RESP_OKAY, 32'hFFFF_FFFF);
  endtask : pkt

  // packet stalled mid-variable-field, then abandoned through the abort bit
  task automatic sc_abort;
    logic [7:0] q[$];
    q.push_back(8'h20);
    for (int k = 0; k < 11; k++) q.push_back(8'hB0 + 8'(k));
    cfg(3'h1, 3'h2, 1'b0, 8'h00, 3'h2, '{16'h1, 16'h0, 16'h0, 16'h0, 16'h0});
    got.delete();
    out_ready <= 1'b0;
    fork
      tx.send(q);
      begin
        repeat (20) @(posedge ref_clk);
        rd(OFS_STATUS, 32'h0000_0001, RESP_OKAY, 32'h0000_0003);
        wr(OFS_CTRL, 32'h0000_0003, RESP_OKAY);
        rd(OFS_STATUS, {16'h0000, 8'(n_pkts), 8'h00}, RESP_OKAY, 32'h0000_FF03);
      end
    join
    out_ready <= 1'b1;
    repeat (20) @(posedge ref_clk);
    chk(got.size(), 8);
    chk({31'h0, got[7][11]}, 32'h0);
  endtask : sc_abort

  task sc_regs;
    rd(OFS_CTRL, 32'h0, RESP_OKAY, 32'hFFFF_FFFF);
    rd(OFS_LEN_CFG, 32'h0000_0021, RESP_OKAY, 32'hFFFF_FFFF);
    rd(OFS_NUM_FLD, 32'h0000_0002, RESP_OKAY, 32'hFFFF_FFFF);
    rd(OFS_FLEN1, 32'h0000_0001, RESP_OKAY, 32'hFFFF_FFFF);
    rd(OFS_FLEN5, 32'h0, RESP_OKAY, 32'hFFFF_FFFF);
    rd(8'h24, 32'h0, RESP_SLVERR, 32'hFFFF_FFFF);
    wr(OFS_STATUS, 32'hFFFF_FFFF, RESP_SLVERR);
  endtask : sc_regs

  task sc_refuse;
    cfg(3'h3, 3'h2, 1'b0, 8'h00, 3'h5, '{16'h1, 16'h2, 16'h2, 16'h1, 16'h1});
    rd(OFS_STATUS, 32'h0000_0002, RESP_OKAY, 32'h0000_0003);
    got.delete();
    tx.send({8'h11, 8'h22, 8'h33, 8'h44});
    repeat (10) @(posedge ref_clk);
    chk(got.size(), 0);
  endtask : sc_refuse

  // clock and cycle ceiling
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      results();
    end
  end

  // output collector
  always @(posedge ref_clk)
    if (out_valid === 1'b1 && out_ready === 1'b1) got.push_back({out_last, out_field, out_data});

  initial begin
    rst_n = 1'b0;
    out_ready = 1'b1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    sc_regs();
    pkt(3'h1, 3'h2, 1'b0, 8'h00, 3'h2, '{16'h1, 16'h0, 16'h0, 16'h0, 16'h0},
        16'h0003, 1'b0);
    pkt(3'h1, 3'h3, 1'b1, 8'h01, 3'h5, '{16'h3, 16'h2, 16'h0, 16'h1, 16'h1},
        16'h0002, 1'b0);
    pkt(3'h4, 3'h5, 1'b0, 8'h00, 3'h5, '{16'h1, 16'h0, 16'h1, 16'h2, 16'h0},
        16'h0004, 1'b0);
    pkt(3'h1, 3'h2, 1'b0, 8'h00, 3'h2, '{16'h1, 16'h0, 16'h0, 16'h0, 16'h0},
        16'h000C, 1'b1);
    sc_refuse();
    sc_abort();
    results();
  end
endmodule : field_rx_parser_tb
